// ===== pls_port_lookup.sv
/*
  pls_port_lookup: master frame port lookup. reads the port index table,
  derives record, data and force addresses, reads the port description
  and checks function code and source/sink role.
  assumes: a simple traffic memory port with req/ack handshake, word
  addresses are byte addresses with bit 0 ignored by the memory.
*/
// Added by the designer: the placing of the registers and register access over APB.
// Behaviour
// RULE_01: modes 2-4: index is bits 11..0
// RULE_02: host writes zero to bits 15..12
// RULE_03: logical index table at address zero
// RULE_04: device table at 04000 or 02000
// RULE_05: derive record, data, force addresses
// RULE_06: record address is base plus index<<3
// RULE_07: record spans four 16-bit words
// RULE_08: words: description, report, acknowledge, check
// RULE_09: report encoding follows line diagnosis bit
// RULE_10: set acknowledge bits on successful transfer
// RULE_11: description word is only ever read
// RULE_12: read description after every selected frame
// RULE_13: mismatched function code ignores the frame
// RULE_14: no function code check in event arbitration
// RULE_15: source flag set means active source
// RULE_16: index zero means unused address
// RULE_17: active sink needs sink set, source clear
// RULE_18: two data, two force addresses per port
`timescale 1ns/100ps
`default_nettype none
module pls_port_lookup
  import pls_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // apb register bus
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // received master frame
  input  wire logic        mf_valid,
  input  wire logic [15:0] master_frame_word,
  input  wire logic        mf_device,
  input  wire logic        event_arb,
  // transfer completion from the data path
  input  wire logic        xfer_done,
  input  wire logic        xfer_ok,
  // traffic memory port
  output logic             tm_req,
  output logic             tm_we,
  output logic      [19:0] tm_addr,
  output logic      [15:0] tm_wdata,
  input  wire logic        tm_ack,
  input  wire logic [15:0] tm_rdata,
  // lookup result
  output logic             port_hit,
  output logic             port_miss,
  output logic      [1:0]  port_role
);
  // lookup steps, one state each
  typedef enum logic [2:0] {S_IDLE, S_PIT, S_DESC, S_DECIDE, S_WAIT,
                            S_ACKW} pls_state_e;
  // all lookup state, kept in one register
  typedef struct packed {
    pls_state_e  state;
    logic [15:0] mf;
    logic        dev;
    logic        evt;
    logic [11:0] pidx;
    logic [15:0] desc;
    logic        hit;
    logic        miss;
    logic [1:0]  role;
    logic [15:0] ack;
    logic [3:0]  report;
    logic        page;
  } pls_core_s;
  pls_core_s   st_r;        // registered state
  pls_core_s   st_nxt;      // next state

  // control values from the register file, derived addresses and status
  logic [2:0]  mode;        // memory_config_mode
  logic        line_diag_enable;
  logic [19:0] rec_base;
  logic [19:0] data_base;
  logic [19:0] force_base;
  logic [19:0] rec_addr;    // port_control_record start
  logic [19:0] data_addr0;
  logic [19:0] data_addr1;
  logic [19:0] force_addr0;
  logic [19:0] force_addr1;
  logic        force_valid;
  logic [19:0] pit_addr;    // table word address for this frame
  logic [31:0] status;        // lookup status for software
  logic [19:0] data_addr_pg;  // data address, current page
  logic [19:0] force_addr_pg; // force address, zero if none

  ////////////////////////////////////////////////////////////////////
  // table word address from the frame's port address;
  // the device table sits higher in mode 1 only
  function automatic logic [19:0] table_base(input logic dev,
                                             input logic [2:0] m);
    if (!dev) begin
      table_base = LOGICAL_TBL_BASE;  // see RULE_03
    end else if (m == 3'h1) begin
      table_base = DEV_TBL_BASE_M1;   // see RULE_04
    end else begin
      table_base = DEV_TBL_BASE_M2;   // see RULE_04
    end
  endfunction

  // modes 0/1 pack two byte indexes; modes 2-4 one word per index
  always_comb begin
    if (mode >= 3'h2) begin
      pit_addr = table_base(st_r.dev, mode) + {7'h0, st_r.mf[11:0], 1'b0};
    end else begin
      // odd indexes share a word with even ones
      pit_addr = table_base(st_r.dev, mode) + {8'h0, st_r.mf[11:1], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // main lookup state machine
  always_comb begin
    st_nxt      = st_r;
    st_nxt.hit  = 1'b0;
    st_nxt.miss = 1'b0;
    // memory port idles low
    tm_req      = 1'b0;
    tm_we       = 1'b0;
    tm_addr     = 20'h0;
    tm_wdata    = 16'h0;
    case (st_r.state)
      S_IDLE: begin
        // accept a new frame only when idle
        if (mf_valid) begin
          st_nxt.mf    = master_frame_word;
          st_nxt.dev   = mf_device;
          st_nxt.evt   = event_arb;
          st_nxt.state = S_PIT;
        end
      end
      S_PIT: begin
        // request stands until the memory answers
        tm_req  = 1'b1;
        tm_addr = pit_addr;
        if (tm_ack) begin
          if (mode >= 3'h2) begin
            // top four bits are ignored
            st_nxt.pidx = tm_rdata[PIDX_HI:0];            // see RULE_01
          end else if (st_r.mf[0]) begin
            st_nxt.pidx = {4'h0, tm_rdata[15:8]};
          end else begin
            st_nxt.pidx = {4'h0, tm_rdata[7:0]};
          end
          st_nxt.state = S_DECIDE;
        end
      end
      S_DECIDE: begin
        // index zero is the unused slot: drop the frame
        if (st_r.pidx == 12'h000) begin                  // see RULE_16
          st_nxt.miss  = 1'b1;
          st_nxt.state = S_IDLE;
        end else begin
          st_nxt.state = S_DESC;
        end
      end
      S_DESC: begin
        // description is read, never written  (see RULE_11, RULE_12)
        tm_req  = 1'b1;
        tm_addr = rec_addr + {17'h0, REC_W_DESC, 1'b0};   // see RULE_08
        if (tm_ack) begin
          st_nxt.desc = tm_rdata;
          // event arbitration skips the compare
          if (!st_r.evt &&
              tm_rdata[PD_FCODE_HI:PD_FCODE_LO] != st_r.mf[15:12]) begin
            st_nxt.miss  = 1'b1;                          // see RULE_13
            st_nxt.state = S_IDLE;
          end else begin
            st_nxt.hit   = 1'b1;                          // see RULE_14
            // source flag wins over sink flag
            if (tm_rdata[PD_SRC_BIT]) begin
              st_nxt.role = PLS_SRC_ACTIVE;               // see RULE_15
            end else if (tm_rdata[PD_SINK_BIT]) begin
              st_nxt.role = PLS_SINK_ACTIVE;              // see RULE_17
            end else begin
              st_nxt.role = PLS_SRC_PASSIVE;
            end
            st_nxt.state = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        // data path reports completion; a failure leaves acks alone.
        // limitation: new frames are refused until then
        if (xfer_done) begin
          st_nxt.report = line_diag_enable ? RPT_LD_OK : RPT_STD_OK; // see RULE_09
          if (xfer_ok) begin
            st_nxt.ack   = st_r.ack | 16'h0001;           // see RULE_10
            st_nxt.page  = ~st_r.page;
            st_nxt.state = S_ACKW;
          end else begin
            st_nxt.state = S_IDLE;
          end
        end
      end
      S_ACKW: begin
        // acknowledge word is word 2 of the four-word record  (see RULE_07)
        tm_req   = 1'b1;
        tm_we    = 1'b1;
        // only bit 0 is set; software clears it
        tm_addr  = rec_addr + {17'h0, REC_W_ACK, 1'b0};
        tm_wdata = st_r.ack;
        if (tm_ack) begin
          st_nxt.state = S_IDLE;
        end
      end
      default: begin
        // unused codes fall back to idle
        st_nxt.state = S_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // state register; sync reset clears outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // results come straight from flip-flops
  assign port_hit  = st_r.hit;
  assign port_miss = st_r.miss;
  assign port_role = st_r.role;
  // status: report, page, role, index
  assign status    = {8'h0, st_r.report, 1'b0, st_r.page, st_r.role,
                      4'h0, st_r.pidx};

  // current page picks the shown addresses
  always_comb begin
    if (st_r.page) begin
      data_addr_pg  = data_addr1;
      force_addr_pg = force_addr1;
    end else begin
      data_addr_pg  = data_addr0;
      force_addr_pg = force_addr0;
    end
    // device ports have no force table  (see RULE_05)
    if (!force_valid) begin
      force_addr_pg = 20'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // address evaluation  (see RULE_05)
  // pure logic: follows the stored index
  pls_addr_map u_map (
    .port_index  (st_r.pidx),
    .rec_base    (rec_base),
    .data_base   (data_base),
    .force_base  (force_base),
    .logical     (~st_r.dev),
    .rec_addr    (rec_addr),
    .data_addr0  (data_addr0),
    .data_addr1  (data_addr1),
    .force_addr0 (force_addr0),
    .force_addr1 (force_addr1),
    .force_valid (force_valid)
  );

  // registers
  pls_apb_regs u_regs (
    .clk              (clk),
    .rst              (rst),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .mode             (mode),
    .line_diag_enable (line_diag_enable),
    .rec_base         (rec_base),
    .data_base        (data_base),
    .force_base       (force_base),
    .status           (status),
    .rec_addr         (rec_addr),
    .data_addr        (data_addr_pg),
    .force_addr       (force_addr_pg),
    .desc             (st_r.desc),
    .ack              (st_r.ack)
  );
endmodule
`default_nettype wire

// ===== pls_pkg.sv
/*
  pls_pkg: constants for the port lookup block (traffic memory layout,
  register offsets, port description fields, timing).
  assumes: 16-bit traffic memory words, 20-bit byte addresses.
*/
package pls_pkg;
  // traffic memory address width (1 MB byte space)
  localparam int unsigned TMA_W            = 20;
  // table starts
  localparam logic [19:0] LOGICAL_TBL_BASE = 20'h00000;
  localparam logic [19:0] DEV_TBL_BASE_M1  = 20'h04000;
  localparam logic [19:0] DEV_TBL_BASE_M2  = 20'h02000;
  // index field of a table word in modes 2..4
  localparam int unsigned PIDX_HI          = 11;
  localparam int unsigned PIDX_W           = 12;
  // record is four words, index shifted by three bytes-wise
  localparam int unsigned REC_SHIFT        = 3;
  localparam int unsigned REC_WORDS        = 4;
  localparam logic [1:0]  REC_W_DESC       = 2'h0;
  localparam logic [1:0]  REC_W_REPORT     = 2'h1;
  localparam logic [1:0]  REC_W_ACK        = 2'h2;
  localparam logic [1:0]  REC_W_CHECK      = 2'h3;
  // port description field positions
  localparam int unsigned PD_FCODE_HI      = 15;
  localparam int unsigned PD_FCODE_LO      = 12;
  localparam int unsigned PD_SRC_BIT       = 11;
  localparam int unsigned PD_SINK_BIT      = 10;
  // apb register offsets
  localparam logic [11:0] REG_CTRL         = 12'h000;
  localparam logic [11:0] REG_REC_BASE     = 12'h004;
  localparam logic [11:0] REG_DATA_BASE    = 12'h008;
  localparam logic [11:0] REG_FORCE_BASE   = 12'h00c;
  localparam logic [11:0] REG_STATUS       = 12'h010;
  localparam logic [11:0] REG_REC_ADDR     = 12'h014;
  localparam logic [11:0] REG_DATA_ADDR    = 12'h018;
  localparam logic [11:0] REG_FORCE_ADDR   = 12'h01c;
  localparam logic [11:0] REG_DESC         = 12'h020;
  localparam logic [11:0] REG_ACK          = 12'h024;
  // control field positions and reset values
  localparam int unsigned CTRL_MODE_LO     = 0;
  localparam int unsigned CTRL_LD_BIT      = 4;
  localparam logic [2:0]  MODE_RST         = 3'h0;
  localparam logic [19:0] REC_BASE_RST     = 20'h0c000;
  localparam logic [19:0] DATA_BASE_RST    = 20'h04000;
  localparam logic [19:0] FORCE_BASE_RST   = 20'h08000;
  // telegram report encodings (one per diagnosis style)
  localparam logic [3:0]  RPT_STD_OK       = 4'h0;
  localparam logic [3:0]  RPT_LD_OK        = 4'h8;
  // memory access latency allowance is handshake based: no timing count
  typedef enum logic [1:0] {PLS_SRC_PASSIVE, PLS_SRC_ACTIVE,
                            PLS_SINK_PASSIVE, PLS_SINK_ACTIVE} pls_role_e;
endpackage

// ===== pls_addr_map.sv
/*
  pls_addr_map: combinational address evaluation from a port index.
  assumes: index already extracted; bases come from registers.
*/
`timescale 1ns/100ps
`default_nettype none
module pls_addr_map
  import pls_pkg::*;
(
  // index and bases
  input  wire logic [11:0] port_index,
  input  wire logic [19:0] rec_base,
  input  wire logic [19:0] data_base,
  input  wire logic [19:0] force_base,
  input  wire logic        logical,
  // derived addresses
  output logic      [19:0] rec_addr,
  output logic      [19:0] data_addr0,
  output logic      [19:0] data_addr1,
  output logic      [19:0] force_addr0,
  output logic      [19:0] force_addr1,
  output logic             force_valid
);
  logic [19:0] map0;  // mapped offset, page 0
  logic [19:0] map1;  // mapped offset, page 1

  // record address: index times eight plus base  (see RULE_06)
  assign rec_addr    = rec_base + {5'h00, port_index, 3'h0};
  // page offsets: 32-byte slot per index, page 1 one slot (32 bytes) above page 0
  assign map0        = {3'h0, port_index, 5'h00} + 20'h000d8 - 20'h001e0;
  assign map1        = map0 + 20'h00020;
  // data and force addresses per page  (see RULE_18)
  assign data_addr0  = data_base + map0;
  assign data_addr1  = data_base + map1;
  assign force_addr0 = force_base + map0;
  assign force_addr1 = force_base + map1;
  // force table only exists for logical ports  (see RULE_05)
  assign force_valid = logical;
endmodule
`default_nettype wire

// ===== pls_apb_regs.sv
/*
  pls_apb_regs: apb slave holding control registers and showing status.
  assumes: zero wait-state apb master, 32-bit data.
*/
`timescale 1ns/100ps
`default_nettype none
module pls_apb_regs
  import pls_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // control out
  output logic      [2:0]  mode,
  output logic             line_diag_enable,
  output logic      [19:0] rec_base,
  output logic      [19:0] data_base,
  output logic      [19:0] force_base,
  // status in
  input  wire logic [31:0] status,
  input  wire logic [19:0] rec_addr,
  input  wire logic [19:0] data_addr,
  input  wire logic [19:0] force_addr,
  input  wire logic [15:0] desc,
  input  wire logic [15:0] ack
);
  typedef struct packed {
    logic [2:0]  mode;
    logic        ld;
    logic [19:0] rb;
    logic [19:0] db;
    logic [19:0] fb;
  } pls_regs_s;
  pls_regs_s st_r;    // registered state
  pls_regs_s st_nxt;  // next state
  logic      wr;      // write strobe

  assign wr      = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // register writes
  always_comb begin
    st_nxt = st_r;
    if (wr && paddr == REG_CTRL) begin
      st_nxt.mode = pwdata[CTRL_MODE_LO +: 3];
      st_nxt.ld   = pwdata[CTRL_LD_BIT];
    end else if (wr && paddr == REG_REC_BASE) begin
      st_nxt.rb = pwdata[19:0];
    end else if (wr && paddr == REG_DATA_BASE) begin
      st_nxt.db = pwdata[19:0];
    end else if (wr && paddr == REG_FORCE_BASE) begin
      st_nxt.fb = pwdata[19:0];
    end
  end

  // state register, synchronous reset
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '{mode: MODE_RST, ld: 1'b0, rb: REC_BASE_RST,
                db: DATA_BASE_RST, fb: FORCE_BASE_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  // read mux; unmapped reads give zero
  always_comb begin
    if (paddr == REG_CTRL) begin
      prdata = {27'h0, st_r.ld, 1'b0, st_r.mode};
    end else if (paddr == REG_REC_BASE) begin
      prdata = {12'h0, st_r.rb};
    end else if (paddr == REG_DATA_BASE) begin
      prdata = {12'h0, st_r.db};
    end else if (paddr == REG_FORCE_BASE) begin
      prdata = {12'h0, st_r.fb};
    end else if (paddr == REG_STATUS) begin
      prdata = status;
    end else if (paddr == REG_REC_ADDR) begin
      prdata = {12'h0, rec_addr};
    end else if (paddr == REG_DATA_ADDR) begin
      prdata = {12'h0, data_addr};
    end else if (paddr == REG_FORCE_ADDR) begin
      prdata = {12'h0, force_addr};
    end else if (paddr == REG_DESC) begin
      prdata = {16'h0, desc};
    end else if (paddr == REG_ACK) begin
      prdata = {16'h0, ack};
    end else begin
      prdata = 32'h0;
    end
  end

  assign mode             = st_r.mode;
  assign line_diag_enable = st_r.ld;
  assign rec_base         = st_r.rb;
  assign data_base        = st_r.db;
  assign force_base       = st_r.fb;
endmodule
`default_nettype wire

// ===== pls_port_lookup_monitor.sv
/*
  pls_port_lookup_monitor: port-level checks of the port lookup block.
  assumes: bound to pls_port_lookup; record base kept 8-byte aligned.
*/
`timescale 1ns/100ps
`default_nettype none
module pls_port_lookup_monitor
  import pls_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // apb handshake
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // frame and completion
  input  wire logic        mf_valid,
  input  wire logic        xfer_done,
  input  wire logic        xfer_ok,
  // memory port
  input  wire logic        tm_req,
  input  wire logic        tm_we,
  input  wire logic [19:0] tm_addr,
  input  wire logic [15:0] tm_wdata,
  input  wire logic        tm_ack,
  // results
  input  wire logic        port_hit,
  input  wire logic        port_miss
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_apb_zero_wait: assert property (psel && penable |-> pready && !pslverr)
    else $error("apb access not answered at once");
  a_lookup_answers: assert property (
    mf_valid && !tm_req |-> ##[2:300] (port_hit || port_miss))
    else $error("frame got no lookup result");
  a_single_outcome: assert property (!(port_hit && port_miss))
    else $error("hit and miss together");
  a_hit_one_cycle: assert property (port_hit |=> !port_hit)
    else $error("hit longer than one cycle");
  a_miss_one_cycle: assert property (port_miss |=> !port_miss)
    else $error("miss longer than one cycle");
  a_req_held: assert property (
    tm_req && !tm_ack |=> tm_req && $stable(tm_addr) && $stable(tm_we))
    else $error("memory request dropped or changed");
  a_desc_read_only: assert property (
    tm_req && tm_we |-> tm_addr[2:1] != 2'h0)
    else $error("write to a port description word");
  a_ack_bit_set: assert property (
    tm_req && tm_we && tm_addr[2:1] == 2'h2 |-> tm_wdata[0])
    else $error("acknowledge write without bit 0");
  a_ack_write_soon: assert property (
    xfer_done && xfer_ok |-> ##[1:50] (tm_req && tm_we))
    else $error("no acknowledge write after transfer");
  a_quiet_release: assert property ($fell(rst) |-> !tm_req && !port_hit)
    else $error("activity right after reset");
endmodule
bind pls_port_lookup pls_port_lookup_monitor u_mon (.clk, .rst, .psel, .penable,
  .pready, .pslverr, .mf_valid, .xfer_done, .xfer_ok, .tm_req, .tm_we, .tm_addr,
  .tm_wdata, .tm_ack, .port_hit, .port_miss);
`default_nettype wire

// ===== pls_tm_model.sv
/*
  pls_tm_model: shared traffic memory with host-side poke and peek.
  assumes: one request held until tm_ack; answer delay set by wait_cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module pls_tm_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // memory port from the block
  input  wire logic        tm_req,
  input  wire logic        tm_we,
  input  wire logic [19:0] tm_addr,
  input  wire logic [15:0] tm_wdata,
  output logic             tm_ack,
  output logic      [15:0] tm_rdata,
  // answer delay
  input  wire logic [1:0]  wait_cycles
);
  logic [15:0] mem [int];  // sparse word store, keyed by even byte address
  logic [1:0]  cnt_r;      // cycles waited on the current request
  function automatic logic [15:0] peek(input logic [19:0] a);
    int k;
    k = int'({a[19:1], 1'b0});
    return mem.exists(k) ? mem[k] : 16'h0000;
  endfunction
  task automatic poke(input logic [19:0] a, input logic [15:0] d);
    mem[int'({a[19:1], 1'b0})] = d;
  endtask
  // answer path; data lines toggle when not answering so stale reads show
  always @(posedge clk) begin
    if (rst) begin
      tm_ack <= 1'b0;
      cnt_r <= 2'h0;
      tm_rdata <= 16'hffff;
    end else if (tm_ack) begin
      tm_ack <= 1'b0;
      tm_rdata <= ~tm_rdata;
      if (tm_req && tm_we) begin
        poke(tm_addr, tm_wdata);
      end
    end else if (tm_req && cnt_r == wait_cycles) begin
      tm_ack <= 1'b1;
      tm_rdata <= peek(tm_addr);
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= tm_req ? cnt_r + 2'h1 : 2'h0;
      tm_rdata <= ~tm_rdata;
    end
  end
endmodule
`default_nettype wire

// ===== pls_port_lookup_bench.sv
/*
  pls_port_lookup_bench: self-checking bench of the port lookup block.
  assumes: pls_tm_model as traffic memory; host set-up done by poke.
*/
`timescale 1ns/100ps
`default_nettype none
module pls_port_lookup_bench
  import pls_pkg::*;
;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        mf_valid, mf_device, event_arb, xfer_done, xfer_ok;
  logic        tm_req, tm_we, tm_ack, port_hit, port_miss;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] master_frame_word, tm_wdata, tm_rdata;
  logic [19:0] tm_addr;
  logic [1:0]  port_role, mem_wait;
  int          mismatches, samples_checked;
  pls_port_lookup u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .mf_valid, .master_frame_word, .mf_device,
    .event_arb, .xfer_done, .xfer_ok, .tm_req, .tm_we, .tm_addr, .tm_wdata,
    .tm_ack, .tm_rdata, .port_hit, .port_miss, .port_role);
  pls_tm_model u_mem (.clk, .rst, .tm_req, .tm_we, .tm_addr, .tm_wdata, .tm_ack,
    .tm_rdata, .wait_cycles(mem_wait));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // port description word: code, source flag, sink flag, rest zero
  function automatic logic [15:0] pd(input logic [3:0] f, input logic s, k);
    return {f, s, k, 10'h000};
  endfunction
  // send one frame and judge the outcome; results sampled mid-cycle
  task automatic frame(input logic [15:0] w, input logic dv, ev, hit,
                       input logic [1:0] role);
    int n;
    n = 0;
    xfer_done <= 1'b1; // fail a transfer an earlier hit left open
    xfer_ok <= 1'b0;
    @(posedge clk);
    xfer_done <= 1'b0;
    mf_valid <= 1'b1;
    master_frame_word <= w;
    mf_device <= dv;
    event_arb <= ev;
    @(posedge clk);
    mf_valid <= 1'b0;
    while (port_hit !== 1'b1 && port_miss !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk("port_hit", port_hit, hit);
    chk("port_miss", port_miss, !hit);
    if (hit) chk("port_role", port_role, role);
    repeat (3) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] r;
    apb(1'b0, REG_REC_BASE, 32'h0, r);
    chk("rec_base", r, {12'h000, REC_BASE_RST});
    apb(1'b0, REG_DATA_BASE, 32'h0, r);
    chk("data_base", r, {12'h000, DATA_BASE_RST});
    apb(1'b0, REG_FORCE_BASE, 32'h0, r);
    chk("force_base", r, {12'h000, FORCE_BASE_RST});
    apb(1'b0, 12'h0f0, 32'h0, r);
    chk("unmapped", r, 32'h0);
    apb(1'b1, REG_CTRL, 32'h12, r);
    apb(1'b0, REG_CTRL, 32'h0, r);
    chk("ctrl", r[4:0], 32'h12);
  endtask
  // worked lookup, then transfer acknowledge
  task automatic t_lookup;
    logic [31:0] r;
    int n;
    u_mem.poke(20'h00468, 16'h000f);
    u_mem.poke(20'h0c078, pd(4'h0, 1'b1, 1'b0));
    frame(16'h0234, 1'b0, 1'b0, 1'b1, 2'h1);
    apb(1'b0, REG_REC_ADDR, 32'h0, r);
    chk("rec_addr", r, 32'h0c078);
    apb(1'b0, REG_DATA_ADDR, 32'h0, r);
    chk("data_addr", r, 32'h040d8);
    apb(1'b0, REG_FORCE_ADDR, 32'h0, r);
    chk("force_addr", r, 32'h080d8);
    apb(1'b0, REG_DESC, 32'h0, r);
    chk("desc", r, {16'h0, pd(4'h0, 1'b1, 1'b0)});
    xfer_done <= 1'b1;
    xfer_ok <= 1'b1;
    @(posedge clk);
    xfer_done <= 1'b0;
    n = 0;
    while (u_mem.peek(20'h0c07c) !== 16'h0001 && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk("ack_word", u_mem.peek(20'h0c07c), 32'h1);
    apb(1'b0, REG_STATUS, 32'h0, r);
    chk("status", r, {8'h00, RPT_LD_OK, 2'h1, 2'h1, 4'h0, 12'h00f});
  endtask
  // code mismatch, then event arbitration codes with a slow memory
  task automatic t_fcode;
    logic [3:0] ev [3] = '{4'h9, 4'hd, 4'he};
    u_mem.poke(20'h0c078, pd(4'h3, 1'b1, 1'b0));
    frame(16'h0234, 1'b0, 1'b0, 1'b0, 2'h0);
    u_mem.poke(20'h0c078, pd(4'h9, 1'b1, 1'b0));
    mem_wait <= 2'h3;
    for (int i = 0; i < 3; i++) frame({ev[i], 12'h234}, 1'b0, 1'b1, 1'b1, 2'h1);
    mem_wait <= 2'h0;
  endtask
  task automatic t_roles;
    logic [1:0] fl [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
    logic [1:0] ex [4] = '{2'h1, 2'h1, 2'h3, 2'h0};
    for (int i = 0; i < 4; i++) begin
      u_mem.poke(20'h0c078, pd(4'h0, fl[i][1], fl[i][0]));
      frame(16'h0234, 1'b0, 1'b0, 1'b1, ex[i]);
    end
    frame(16'h0100, 1'b0, 1'b0, 1'b0, 2'h0);
  endtask
  task automatic t_device;
    logic [31:0] r;
    u_mem.poke(20'h0200a, 16'h0021);
    u_mem.poke(20'h0c108, pd(4'h0, 1'b0, 1'b1));
    frame(16'h0005, 1'b1, 1'b0, 1'b1, 2'h3);
    apb(1'b1, REG_CTRL, 32'h1, r);
    u_mem.poke(20'h04006, 16'h0021);
    frame(16'h0006, 1'b1, 1'b0, 1'b1, 2'h3);
    xfer_done <= 1'b1;
    @(posedge clk);
    xfer_done <= 1'b0;
    apb(1'b0, REG_STATUS, 32'h0, r);
    chk("status", r, {8'h00, RPT_STD_OK, 2'h1, 2'h3, 4'h0, 12'h021});
    apb(1'b0, REG_FORCE_ADDR, 32'h0, r);
    chk("force_addr", r, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog: the whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude;
  end
  initial begin
    {rst, psel, penable, pwrite, mf_valid, mf_device} = 6'h20;
    {event_arb, xfer_done, xfer_ok} = 3'h0;
    {paddr, pwdata, master_frame_word, mem_wait} = '0;
    mismatches = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_lookup;
    t_fcode;
    t_roles;
    t_device;
    conclude;
  end
endmodule
`default_nettype wire
